//--- src/rfa_arbiter.sv
// redundancy failover arbiter: peer supervision, role settling, relay control
// assumes peer link framing outside; pins are asynchronous, rx words are on aclk
//
// Added by the designer: register access over AXI4-Lite and the register offsets.
module rfa_arbiter #(
  parameter int CYC_PER_MS = rfa_pkg::DEF_CYC_PER_MS
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire rfa_pkg::rfa_axi_req_t axi_req,
  output rfa_pkg::rfa_axi_rsp_t axi_rsp,
  // peer link heartbeat lines
  output logic dtr_out,
  input wire logic dsr_in,
  // peer link status messages
  output logic tx_valid,
  output rfa_pkg::rfa_msg_t tx_msg,
  input wire logic rx_valid,
  input wire rfa_pkg::rfa_msg_t rx_msg,
  // relay and operator pins
  input wire logic handover_request_input,
  input wire logic relay_feedback_input,
  output logic relay_command_output,
  // local plant side
  input wire logic [15:0] local_anom_set,
  output rfa_pkg::rfa_image_t out_image,
  output logic [15:0] displayed_anom,
  output logic role_active,
  output logic gen_control_enable,
  output logic fieldbus_tx_enable,
  // alarms
  output logic primary_failure_warning,
  output logic relay_failure_warning,
  output logic secondary_failure_warning,
  output logic wrong_config_alarm
);

  localparam int CW = (CYC_PER_MS > 1) ? $clog2(CYC_PER_MS) : 1;
  localparam logic [CW-1:0] PRESCALE_LAST = CW'(CYC_PER_MS - 1);

  // refuse a time base the prescaler cannot produce
  if (CYC_PER_MS < 2) begin : g_bad_rate
    $error("CYC_PER_MS must be at least 2");
  end

  typedef struct packed {
    logic [1:0] dsr_s;
    logic dsr_prev;
    logic [1:0] ho_s;
    logic ho_prev;
    logic [1:0] fb_s;
    logic fb_prev;
    logic [CW-1:0] pre;
    logic ms_tick;
    logic dtr;
    rfa_pkg::rfa_role_t role;
    logic relay_cmd;
    rfa_pkg::rfa_warn_t warn;
    logic wrong_cfg;
    rfa_pkg::rfa_ctrl_t ctrl;
    logic [15:0] brk_map;
    rfa_pkg::rfa_image_t loc_img;
    rfa_pkg::rfa_image_t mir_img;
    rfa_pkg::rfa_image_t out_img;
    logic [15:0] own_anom;
    logic [15:0] mir_anom;
    logic [15:0] disp_anom;
    logic tx_valid;
    rfa_pkg::rfa_msg_t tx_msg;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rfa_core_state_t;

  rfa_core_state_t st;
  rfa_core_state_t next_st;

  logic [rfa_pkg::NT-1:0] t_restart;
  logic [rfa_pkg::NT-1:0] t_done;
  logic [rfa_pkg::TW-1:0] t_limit [rfa_pkg::NT];

  logic aw_take;
  logic ar_take;
  logic [31:0] wmask;
  logic [32:0] wr_old;
  logic [32:0] rd_word;
  logic [31:0] wr_val;
  logic dsr_edge;
  logic ho_rise;
  logic fb;
  logic fb_chg;
  logic peer_fail;
  logic peer_msg;
  logic is_pri;
  logic exp_fb_active;
  logic exp_fb_standby;
  logic active_role;
  rfa_pkg::rfa_warn_t warn_set;
  rfa_pkg::rfa_warn_t warn_clr;

  // register read mux over the current state
  function automatic logic [32:0] read_word(input logic [rfa_pkg::AW-1:0] a);
    rfa_pkg::rfa_status_t s;
    logic [32:0] r;
    s = '0;
    s.role = st.role;
    s.active = active_role;
    s.peer_failed = peer_fail;
    s.relay_command = st.relay_cmd;
    s.relay_feedback = st.fb_s[1];
    s.wrong_config_alarm = st.wrong_cfg;
    s.msg_lost = t_done[rfa_pkg::T_MSG];
    s.dsr_lost = t_done[rfa_pkg::T_DSR];
    r = {1'b0, 32'h0000_0000};
    case (a)
      rfa_pkg::REG_CTRL: r[31:0] = st.ctrl;
      rfa_pkg::REG_BRK_MAP: r[31:0] = {16'h0000, st.brk_map};
      rfa_pkg::REG_DOUT: r[31:0] = {16'h0000, st.loc_img.dout};
      rfa_pkg::REG_AOUT: r[31:0] = {st.loc_img.aout1, st.loc_img.aout0};
      rfa_pkg::REG_STATUS: r[31:0] = s;
      rfa_pkg::REG_WARN: r[31:0] = st.warn;
      rfa_pkg::REG_ANOM: r[31:0] = {16'h0000, st.disp_anom};
      default: r[32] = 1'b1;
    endcase
    return r;
  endfunction

  // interval timers: heartbeat, transmit, message loss, heartbeat loss, phase
  for (genvar g = 0; g < rfa_pkg::NT; g++) begin : g_tmr
    rfa_ms_timer #(
      .W(rfa_pkg::TW)
    ) u_tmr (
      .aclk(aclk),
      .aresetn(aresetn),
      .restart(t_restart[g]),
      .ms_tick(st.ms_tick),
      .limit(t_limit[g]),
      .done(t_done[g])
    );
  end

  // derived conditions from synchronised pins and timers
  always_comb begin
    dsr_edge = st.dsr_s[1] ^ st.dsr_prev;
    ho_rise = st.ho_s[1] & ~st.ho_prev;
    fb = st.fb_s[1];
    fb_chg = st.fb_s[1] ^ st.fb_prev;
    peer_fail = t_done[rfa_pkg::T_MSG] | t_done[rfa_pkg::T_DSR];
    peer_msg = rx_valid & (rx_msg.is_secondary != st.ctrl.is_secondary);
    is_pri = ~st.ctrl.is_secondary;
    exp_fb_active = ~is_pri;
    exp_fb_standby = is_pri;
    active_role = (st.role == rfa_pkg::ST_SETTLE) || (st.role == rfa_pkg::ST_ACTIVE) ||
      (st.role == rfa_pkg::ST_RELEASE);
  end

  // bus handshakes: write address and data are taken together
  always_comb begin
    aw_take = axi_req.awvalid & axi_req.wvalid & ~st.bvalid;
    ar_take = axi_req.arvalid & ~st.rvalid;
    for (int i = 0; i < 4; i++) begin
      wmask[8*i +: 8] = {8{axi_req.wstrb[i]}};
    end
    wr_old = read_word(axi_req.awaddr);
    rd_word = read_word(axi_req.araddr);
    wr_val = (wr_old[31:0] & ~wmask) | (axi_req.wdata & wmask);
  end

  // main next-state logic
  always_comb begin
    next_st = st;
    warn_set = '0;
    warn_clr = '0;

    // pin synchronisers
    next_st.dsr_s = {st.dsr_s[0], dsr_in};
    next_st.dsr_prev = st.dsr_s[1];
    next_st.ho_s = {st.ho_s[0], handover_request_input};
    next_st.ho_prev = st.ho_s[1];
    next_st.fb_s = {st.fb_s[0], relay_feedback_input};
    next_st.fb_prev = st.fb_s[1];

    // millisecond tick
    next_st.ms_tick = (st.pre == PRESCALE_LAST);
    next_st.pre = next_st.ms_tick ? '0 : CW'(st.pre + 1'b1);

    // heartbeat toggle
    if (t_done[rfa_pkg::T_HB]) begin
      next_st.dtr = ~st.dtr;
    end

    // role sequencing
    case (st.role)
      rfa_pkg::ST_POWERUP: begin
        if (peer_msg && rx_msg.active) begin
          next_st.role = rfa_pkg::ST_STANDBY;
        end else if (peer_msg && is_pri) begin
          next_st.role = rfa_pkg::ST_SETTLE;
        end else if (t_done[rfa_pkg::T_PH]) begin
          next_st.role = rfa_pkg::ST_SETTLE;
          next_st.relay_cmd = st.ctrl.is_secondary;
        end
      end
      rfa_pkg::ST_STANDBY: begin
        if (st.ctrl.is_secondary && peer_fail) begin
          warn_set.primary_failure_warning = 1'b1;
          next_st.relay_cmd = 1'b1;
          next_st.role = rfa_pkg::ST_SETTLE;
        end else if (is_pri && ho_rise) begin
          next_st.role = rfa_pkg::ST_SETTLE;
        end
      end
      rfa_pkg::ST_SETTLE: begin
        if (t_done[rfa_pkg::T_PH]) begin
          next_st.role = rfa_pkg::ST_ACTIVE;
          if (fb != exp_fb_active) begin
            warn_set.relay_failure_warning = 1'b1;
          end
        end
      end
      rfa_pkg::ST_ACTIVE: begin
        if (st.ctrl.is_secondary) begin
          if (ho_rise) begin
            next_st.relay_cmd = 1'b0;
            next_st.role = rfa_pkg::ST_RELEASE;
          end
          if (fb != exp_fb_active) begin
            warn_set.relay_failure_warning = 1'b1;
          end
        end else if (fb != exp_fb_active) begin
          warn_set.primary_failure_warning = 1'b1;
          next_st.role = rfa_pkg::ST_STANDBY;
        end
      end
      rfa_pkg::ST_RELEASE: begin
        if (t_done[rfa_pkg::T_PH]) begin
          next_st.role = rfa_pkg::ST_STANDBY;
          if (fb != exp_fb_standby) begin
            warn_set.relay_failure_warning = 1'b1;
          end
        end
      end
      default: begin
        next_st.role = rfa_pkg::ST_POWERUP;
      end
    endcase

    // lost peer while the secondary still holds the relay
    if (is_pri && peer_fail && fb) begin
      warn_set.secondary_failure_warning = 1'b1;
    end

    // wrong configuration
    next_st.wrong_cfg = (|st.brk_map) & ~st.ctrl.app_ok;

    // mirroring of images and anomalies from the peer
    if (peer_msg) begin
      next_st.mir_img = rx_msg.image;
      next_st.mir_anom = rx_msg.anomalies;
    end
    if (st.role == rfa_pkg::ST_ACTIVE) begin
      next_st.mir_anom = st.mir_anom | local_anom_set;
    end
    if (next_st.role == rfa_pkg::ST_SETTLE && st.role != rfa_pkg::ST_SETTLE) begin
      next_st.own_anom = '0;
    end
    next_st.own_anom = next_st.own_anom | local_anom_set;
    next_st.disp_anom = active_role ? st.mir_anom : st.own_anom;

    // output image: own in ST_ACTIVE, mirrored in every other role
    next_st.out_img = (st.role == rfa_pkg::ST_ACTIVE) ? st.loc_img : st.mir_img;

    // periodic status message
    next_st.tx_valid = t_done[rfa_pkg::T_TX];
    if (t_done[rfa_pkg::T_TX]) begin
      next_st.tx_msg.is_secondary = st.ctrl.is_secondary;
      next_st.tx_msg.active = active_role;
      next_st.tx_msg.image = st.out_img;
      next_st.tx_msg.anomalies = st.mir_anom;
    end

    // register writes
    if (aw_take) begin
      next_st.bvalid = 1'b1;
      next_st.bresp = rfa_pkg::RESP_OKAY;
      case (axi_req.awaddr)
        rfa_pkg::REG_CTRL: begin
          next_st.ctrl = rfa_pkg::rfa_ctrl_t'({30'h0000_0000, wr_val[1:0]});
        end
        rfa_pkg::REG_BRK_MAP: next_st.brk_map = wr_val[15:0];
        rfa_pkg::REG_DOUT: next_st.loc_img.dout = wr_val[15:0];
        rfa_pkg::REG_AOUT: begin
          next_st.loc_img.aout1 = wr_val[31:16];
          next_st.loc_img.aout0 = wr_val[15:0];
        end
        rfa_pkg::REG_WARN: warn_clr = rfa_pkg::rfa_warn_t'(axi_req.wdata & wmask);
        rfa_pkg::REG_STATUS, rfa_pkg::REG_ANOM: next_st.bresp = rfa_pkg::RESP_OKAY;
        default: next_st.bresp = rfa_pkg::RESP_SLVERR;
      endcase
    end else if (axi_req.bready) begin
      next_st.bvalid = 1'b0;
    end

    // sticky warnings: a new event wins over a clear
    next_st.warn = (st.warn & ~warn_clr) | warn_set;
    next_st.warn.rsvd = '0;

    // register reads
    if (ar_take) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = rd_word[31:0];
      next_st.rresp = rd_word[32] ? rfa_pkg::RESP_SLVERR : rfa_pkg::RESP_OKAY;
    end else if (axi_req.rready) begin
      next_st.rvalid = 1'b0;
    end
  end

  // timer restarts and limits
  always_comb begin
    t_restart[rfa_pkg::T_HB] = t_done[rfa_pkg::T_HB];
    t_restart[rfa_pkg::T_TX] = t_done[rfa_pkg::T_TX];
    t_restart[rfa_pkg::T_MSG] = peer_msg;
    t_restart[rfa_pkg::T_DSR] = dsr_edge;
    t_restart[rfa_pkg::T_PH] = (next_st.role != st.role) ||
      ((st.role == rfa_pkg::ST_SETTLE) && fb_chg);
    t_limit[rfa_pkg::T_HB] = rfa_pkg::HB_MS;
    t_limit[rfa_pkg::T_TX] = rfa_pkg::TX_MS;
    t_limit[rfa_pkg::T_MSG] = rfa_pkg::MSG_TO_MS;
    t_limit[rfa_pkg::T_DSR] = rfa_pkg::DSR_TO_MS;
    case (st.role)
      rfa_pkg::ST_POWERUP: begin
        t_limit[rfa_pkg::T_PH] = st.ctrl.is_secondary ? rfa_pkg::WIN_SEC_MS :
          rfa_pkg::WIN_PRI_MS;
      end
      rfa_pkg::ST_RELEASE: t_limit[rfa_pkg::T_PH] = rfa_pkg::RELEASE_MS;
      default: t_limit[rfa_pkg::T_PH] = rfa_pkg::SETTLE_MS;
    endcase
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // outputs
  always_comb begin
    axi_rsp.awready = aw_take;
    axi_rsp.wready = aw_take;
    axi_rsp.bvalid = st.bvalid;
    axi_rsp.bresp = st.bresp;
    axi_rsp.arready = ~st.rvalid;
    axi_rsp.rvalid = st.rvalid;
    axi_rsp.rdata = st.rdata;
    axi_rsp.rresp = st.rresp;
  end

  assign dtr_out = st.dtr;
  assign tx_valid = st.tx_valid;
  assign tx_msg = st.tx_msg;
  assign relay_command_output = st.relay_cmd;
  assign out_image = st.out_img;
  assign displayed_anom = st.disp_anom;
  assign role_active = active_role;
  // only a settled active unit runs and transmits
  assign gen_control_enable = (st.role == rfa_pkg::ST_ACTIVE) & ~st.wrong_cfg;
  assign fieldbus_tx_enable = (st.role == rfa_pkg::ST_ACTIVE) & ~st.wrong_cfg;
  assign primary_failure_warning = st.warn.primary_failure_warning;
  assign relay_failure_warning = st.warn.relay_failure_warning;
  assign secondary_failure_warning = st.warn.secondary_failure_warning;
  assign wrong_config_alarm = st.wrong_cfg;

endmodule

//--- src/rfa_ms_timer.sv
// millisecond interval timer: counts ticks after a restart up to a limit
// assumes a one-cycle ms tick from the same clock domain
module rfa_ms_timer #(
  parameter int W = 11
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic restart,
  input wire logic ms_tick,
  input wire logic [W-1:0] limit,
  // result
  output logic done
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic done;
  } rfa_tmr_state_t;

  rfa_tmr_state_t st;
  rfa_tmr_state_t next_st;

  // count ticks, saturate once the limit is reached
  always_comb begin
    next_st = st;
    if (restart) begin
      next_st.cnt = '0;
    end else if (ms_tick && !st.done) begin
      next_st.cnt = W'(st.cnt + 1'b1);
    end
    next_st.done = !restart && (next_st.cnt >= limit);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign done = st.done;

endmodule

//--- src/rfa_pkg.sv
// constants, register map and carrier types of the redundancy failover arbiter
// assumes a 250 MHz aclk and a peer link whose serial framing lives outside
package rfa_pkg;

  // time base
  localparam int CLK_PERIOD_NS = 4;
  localparam int MS_NS = 1000000;
  localparam int DEF_CYC_PER_MS = MS_NS / CLK_PERIOD_NS;

  // protocol and sequencing times in milliseconds
  localparam int TW = 11;
  localparam logic [TW-1:0] HB_MS = 11'd5;
  localparam logic [TW-1:0] TX_MS = 11'd100;
  localparam logic [TW-1:0] MSG_TO_MS = 11'd250;
  localparam logic [TW-1:0] DSR_TO_MS = 11'd25;
  localparam logic [TW-1:0] WIN_PRI_MS = 11'd500;
  localparam logic [TW-1:0] WIN_SEC_MS = 11'd1000;
  localparam logic [TW-1:0] SETTLE_MS = 11'd200;
  localparam logic [TW-1:0] RELEASE_MS = 11'd300;

  // timer slots
  localparam int NT = 5;
  localparam int T_HB = 0;
  localparam int T_TX = 1;
  localparam int T_MSG = 2;
  localparam int T_DSR = 3;
  localparam int T_PH = 4;

  // register byte offsets
  localparam int AW = 8;
  localparam logic [AW-1:0] REG_CTRL = 8'h00;
  localparam logic [AW-1:0] REG_BRK_MAP = 8'h04;
  localparam logic [AW-1:0] REG_DOUT = 8'h08;
  localparam logic [AW-1:0] REG_AOUT = 8'h0C;
  localparam logic [AW-1:0] REG_STATUS = 8'h10;
  localparam logic [AW-1:0] REG_WARN = 8'h14;
  localparam logic [AW-1:0] REG_ANOM = 8'h18;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_POWERUP = 3'b000,
    ST_STANDBY = 3'b001,
    ST_SETTLE = 3'b010,
    ST_ACTIVE = 3'b011,
    ST_RELEASE = 3'b100
  } rfa_role_t;

  typedef struct packed {
    logic [29:0] rsvd;
    logic app_ok;
    logic is_secondary;
  } rfa_ctrl_t;

  typedef struct packed {
    logic [28:0] rsvd;
    logic secondary_failure_warning;
    logic relay_failure_warning;
    logic primary_failure_warning;
  } rfa_warn_t;

  typedef struct packed {
    logic [21:0] rsvd;
    logic dsr_lost;
    logic msg_lost;
    logic wrong_config_alarm;
    logic relay_feedback;
    logic relay_command;
    logic peer_failed;
    logic active;
    rfa_role_t role;
  } rfa_status_t;

  localparam rfa_ctrl_t CTRL_RESET = '0;
  localparam rfa_warn_t WARN_RESET = '0;

  typedef struct packed {
    logic [15:0] dout;
    logic [15:0] aout1;
    logic [15:0] aout0;
  } rfa_image_t;

  typedef struct packed {
    logic is_secondary;
    logic active;
    rfa_image_t image;
    logic [15:0] anomalies;
  } rfa_msg_t;

  typedef struct packed {
    logic awvalid;
    logic [AW-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [AW-1:0] araddr;
    logic rready;
  } rfa_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rfa_axi_rsp_t;

endpackage

//--- testbench/rfa_arbiter_properties.sv
// port checker of the arbiter: heartbeat, status rate, roles, settling
// assumes a bind into rfa_arbiter with its CYC_PER_MS handed on
module rfa_checker #(
  parameter int CYC_PER_MS = 10
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // peer link
  input wire logic dtr_out,
  input wire logic tx_valid,
  input wire rfa_pkg::rfa_msg_t tx_msg,
  input wire logic rx_valid,
  input wire rfa_pkg::rfa_msg_t rx_msg,
  // relay and plant side
  input wire logic relay_feedback_input,
  input wire logic relay_command_output,
  input wire rfa_pkg::rfa_image_t out_image,
  input wire logic role_active,
  input wire logic gen_control_enable,
  input wire logic fieldbus_tx_enable,
  input wire logic wrong_config_alarm
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HB = 5 * CYC_PER_MS;
  localparam int TXC = 100 * CYC_PER_MS;
  localparam int SET = 200 * CYC_PER_MS;
  int hb_cnt;
  int tx_cnt;
  int st_cnt;
  logic dtr_q;
  logic fb_q;
  logic hb_seen;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // cycles since last heartbeat edge, status pulse and settling cause
  always_ff @(posedge aclk) begin
    dtr_q <= dtr_out;
    fb_q <= relay_feedback_input;
    if (!aresetn) begin
      hb_cnt <= 0;
      tx_cnt <= 0;
      st_cnt <= 0;
      hb_seen <= 1'b0;
    end else begin
      hb_cnt <= (dtr_out != dtr_q) ? 0 : hb_cnt + 1;
      tx_cnt <= tx_valid ? 0 : tx_cnt + 1;
      st_cnt <= (!role_active || relay_feedback_input != fb_q) ? 0 : st_cnt + 1;
      hb_seen <= hb_seen || (dtr_out != dtr_q);
    end
  end

  hb_bound_a:
    assert property (hb_cnt <= HB + 4) else $error("heartbeat held too long");
  hb_spacing_a:
    assert property (hb_seen && dtr_out != dtr_q |-> hb_cnt >= HB - 4)
      else $error("heartbeat toggled too early");
  status_rate_a:
    assert property (tx_cnt <= TXC + 4) else $error("status message overdue");
  status_pulse_a:
    assert property (tx_valid |=> !tx_valid) else $error("status pulse too long");
  primary_relay_a:
    assert property (tx_valid && !tx_msg.is_secondary |-> !relay_command_output)
      else $error("primary drives the relay");
  standby_quiet_a:
    assert property (!role_active |-> !gen_control_enable && !fieldbus_tx_enable)
      else $error("standby unit enables control");
  wrong_cfg_a:
    assert property (wrong_config_alarm |-> !gen_control_enable && !fieldbus_tx_enable)
      else $error("bad configuration leaves control on");
  settle_wait_a:
    assert property ($rose(gen_control_enable) |-> st_cnt >= SET - 4)
      else $error("control started before settling");
  mirror_image_a:
    assert property (rx_valid && !role_active ##1 !role_active [*2]
      |-> out_image == $past(rx_msg.image, 2)) else $error("image not mirrored");
endmodule

bind rfa_arbiter rfa_checker #(.CYC_PER_MS(CYC_PER_MS)) chk (
  .aclk(aclk), .aresetn(aresetn), .dtr_out(dtr_out), .tx_valid(tx_valid),
  .tx_msg(tx_msg), .rx_valid(rx_valid), .rx_msg(rx_msg),
  .relay_feedback_input(relay_feedback_input),
  .relay_command_output(relay_command_output), .out_image(out_image),
  .role_active(role_active), .gen_control_enable(gen_control_enable),
  .fieldbus_tx_enable(fieldbus_tx_enable), .wrong_config_alarm(wrong_config_alarm)
);

//--- testbench/rfa_peer_model.sv
// peer controller model: heartbeat line and periodic status messages
// assumes the arbiter's aclk; a dead peer freezes its heartbeat line
module rfa_peer_model #(
  parameter int CYC_PER_MS = 10
) (
  // clock
  input wire logic aclk,
  // behaviour set by the bench
  input wire logic alive,
  input wire logic is_secondary,
  input wire logic active,
  input wire rfa_pkg::rfa_image_t image,
  // link toward the arbiter
  output logic dtr = 1'b0,
  output logic rx_valid = 1'b0,
  output rfa_pkg::rfa_msg_t rx_msg = '0
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;

  // dtr toggles every 5 ms, a message goes out every 50 ms
  always @(posedge aclk) begin
    rx_valid <= 1'b0;
    rx_msg <= ~rx_msg; // stale payload never lingers
    cnt <= alive ? cnt + 1 : 0;
    if (alive && cnt % (5 * CYC_PER_MS) == 0) dtr <= ~dtr;
    if (alive && cnt % (50 * CYC_PER_MS) == 7) begin
      rx_valid <= 1'b1;
      rx_msg <= '{is_secondary, active, image, 16'h00A5};
    end
  end
endmodule

//--- testbench/testbench.sv
// top bench: arbiter and peer model through power-on, takeover, handover
// assumes a shortened millisecond of CPM clock cycles
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CPM = 10;
  `define CHECK(nm, ex, gt) begin \
    n_compared++; \
    if ((gt) !== (ex)) begin \
      err_count++; \
      $display("ERROR %s expected %h seen %h", nm, ex, gt); \
    end \
  end

  // design and peer connections
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  rfa_pkg::rfa_axi_req_t axi_req = '0;
  rfa_pkg::rfa_axi_rsp_t axi_rsp;
  rfa_pkg::rfa_msg_t tx_msg, rx_msg;
  rfa_pkg::rfa_image_t out_image;
  rfa_pkg::rfa_image_t p_img = '0;
  logic dtr_out, dsr_in, tx_valid, rx_valid, role_active, gen_en, bus_en;
  logic pf_warn, rf_warn, sf_warn, cfg_alarm, relay;
  logic handover = 1'b0;
  logic feedback = 1'b0;
  logic p_alive = 1'b0;
  logic p_sec = 1'b0;
  logic p_act = 1'b0;
  logic [15:0] anom = '0;
  logic [15:0] disp;
  logic [31:0] q, dv, av;
  logic [1:0] r;
  int err_count = 0;
  int n_compared = 0;

  // 250 MHz clock
  always #2 aclk = ~aclk;

  rfa_arbiter #(.CYC_PER_MS(CPM)) uut (
    .aclk(aclk), .aresetn(aresetn), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .dtr_out(dtr_out), .dsr_in(dsr_in), .tx_valid(tx_valid), .tx_msg(tx_msg),
    .rx_valid(rx_valid), .rx_msg(rx_msg), .handover_request_input(handover),
    .relay_feedback_input(feedback), .relay_command_output(relay),
    .local_anom_set(anom), .out_image(out_image), .displayed_anom(disp),
    .role_active(role_active), .gen_control_enable(gen_en),
    .fieldbus_tx_enable(bus_en), .primary_failure_warning(pf_warn),
    .relay_failure_warning(rf_warn), .secondary_failure_warning(sf_warn),
    .wrong_config_alarm(cfg_alarm)
  );

  rfa_peer_model #(.CYC_PER_MS(CPM)) peer (
    .aclk(aclk), .alive(p_alive), .is_secondary(p_sec), .active(p_act),
    .image(p_img), .dtr(dsr_in), .rx_valid(rx_valid), .rx_msg(rx_msg)
  );

  // counts and verdict, then end of run
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // expected warning register word from the three sticky flags
  function automatic logic [31:0] warn_word(input logic pf, input logic rf, input logic sf);
    return {29'h0000_0000, sf, rf, pf};
  endfunction

  // n milliseconds of the shortened time base
  task automatic ms(input int n);
    repeat (n * CPM) @(posedge aclk);
  endtask

  // one register access; every channel wait is bounded
  task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge aclk);
    if (wr) axi_req <= '{awvalid: 1'b1, awaddr: a, wvalid: 1'b1, wdata: d,
                         wstrb: 4'hF, bready: 1'b1, default: '0};
    else axi_req <= '{arvalid: 1'b1, araddr: a, rready: 1'b1, default: '0};
    do begin
      @(posedge aclk);
      i++;
    end while (!(wr ? axi_rsp.awready && axi_rsp.wready : axi_rsp.arready) && i < 99);
    axi_req.awvalid <= 1'b0;
    axi_req.wvalid <= 1'b0;
    axi_req.arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      i++;
    end while (!(wr ? axi_rsp.bvalid : axi_rsp.rvalid) && i < 99);
    q = axi_rsp.rdata;
    r = wr ? axi_rsp.bresp : axi_rsp.rresp;
    axi_req.bready <= 1'b0;
    axi_req.rready <= 1'b0;
    if (i >= 99) begin
      err_count++;
      $display("ERROR handshake expected 1 seen 0");
      wrap_up();
    end
  endtask

  // write expecting an OKAY response
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi(1'b1, a, d);
    `CHECK("bresp", rfa_pkg::RESP_OKAY, r)
  endtask

  // synchronous reset with the peer held dead
  task automatic restart(input int n);
    @(posedge aclk);
    aresetn <= 1'b0;
    p_alive <= 1'b0;
    repeat (n) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  // main sequence
  initial begin
    void'($urandom(73106));
    restart(12);
    axi(1'b0, rfa_pkg::REG_WARN, '0);
    `CHECK("warn reset", warn_word(1'b0, 1'b0, 1'b0), q)
    axi(1'b0, 8'h40, '0);
    `CHECK("unmapped resp", rfa_pkg::RESP_SLVERR, r)
    `CHECK("unmapped data", 32'h0, q)
    $display("test reset done");
    dv = $urandom;
    av = $urandom;
    wr(rfa_pkg::REG_CTRL, 32'h2);
    wr(rfa_pkg::REG_DOUT, dv);
    wr(rfa_pkg::REG_AOUT, av);
    ms(495);
    `CHECK("powerup standby", 1'b0, role_active)
    ms(10);
    `CHECK("primary alone", 1'b1, role_active)
    ms(190);
    `CHECK("settle hold", 1'b0, gen_en)
    ms(10);
    `CHECK("control on", 1'b1, gen_en)
    `CHECK("local image", {dv[15:0], av}, out_image)
    feedback <= 1'b1;
    ms(5);
    `CHECK("takeover seen", 1'b1, pf_warn)
    `CHECK("secondary lost", 1'b1, sf_warn)
    `CHECK("standby bus", 1'b0, bus_en)
    axi(1'b0, rfa_pkg::REG_WARN, '0);
    `CHECK("warn reg", warn_word(1'b1, 1'b0, 1'b1), q)
    axi(1'b0, rfa_pkg::REG_STATUS, '0);
    `CHECK("message loss", 1'b1, q[8])
    `CHECK("heartbeat loss", 1'b1, q[9])
    feedback <= 1'b0;
    handover <= 1'b1;
    ms(195);
    `CHECK("handover settle", 1'b0, gen_en)
    ms(10);
    `CHECK("handover run", 1'b1, gen_en)
    `CHECK("handover relay ok", 1'b0, rf_warn)
    handover <= 1'b0;
    $display("test primary done");
    restart(2);
    p_img <= {16'($urandom), 32'($urandom)};
    p_act <= 1'b1;
    wr(rfa_pkg::REG_CTRL, 32'h3);
    p_alive <= 1'b1;
    ms(1010);
    `CHECK("secondary yields", 1'b0, role_active)
    `CHECK("mirror image", p_img, out_image)
    dv = 32'h100 << ($urandom % 8);
    anom <= dv[15:0];
    @(posedge aclk);
    anom <= '0;
    ms(1);
    `CHECK("own anomalies", dv[15:0], disp)
    p_alive <= 1'b0;
    ms(19);
    `CHECK("heartbeat grace", 1'b0, relay)
    ms(12);
    `CHECK("takeover relay", 1'b1, relay)
    `CHECK("takeover warn", 1'b1, pf_warn)
    feedback <= 1'b1;
    ms(195);
    `CHECK("takeover settle", 1'b0, gen_en)
    ms(10);
    `CHECK("takeover run", 1'b1, gen_en)
    `CHECK("mirrored set kept", 16'h00A5, disp)
    `CHECK("feedback ok", 1'b0, rf_warn)
    p_act <= 1'b0;
    p_alive <= 1'b1;
    ms(60);
    handover <= 1'b1;
    ms(1);
    `CHECK("release relay", 1'b0, relay)
    ms(290);
    `CHECK("release hold", 1'b1, role_active)
    ms(15);
    `CHECK("release standby", 1'b0, role_active)
    `CHECK("release feedback bad", 1'b1, rf_warn)
    ms(40);
    `CHECK("level ignored", 1'b0, relay)
    handover <= 1'b0;
    wr(rfa_pkg::REG_WARN, 32'h2);
    axi(1'b0, rfa_pkg::REG_WARN, '0);
    `CHECK("warn cleared", warn_word(1'b1, 1'b0, 1'b0), q)
    $display("test secondary done");
    restart(2);
    p_sec <= 1'b1;
    feedback <= 1'b0;
    wr(rfa_pkg::REG_CTRL, 32'h2);
    p_alive <= 1'b1;
    ms(2);
    `CHECK("early active", 1'b1, role_active)
    $display("test early done");
    restart(2);
    p_act <= 1'b1;
    feedback <= 1'b1;
    wr(rfa_pkg::REG_CTRL, 32'h2);
    p_alive <= 1'b1;
    ms(600);
    `CHECK("primary yields", 1'b0, role_active)
    wr(rfa_pkg::REG_BRK_MAP, {16'h0, 16'($urandom) | 16'h1});
    wr(rfa_pkg::REG_CTRL, 32'h0);
    ms(1);
    `CHECK("breaker alarm", 1'b1, cfg_alarm)
    wr(rfa_pkg::REG_CTRL, 32'h2);
    ms(1);
    `CHECK("plant app ok", 1'b0, cfg_alarm)
    $display("test config done");
    restart(2);
    p_sec <= 1'b0;
    p_act <= 1'b0;
    feedback <= 1'b0;
    wr(rfa_pkg::REG_CTRL, 32'h3);
    p_alive <= 1'b1;
    ms(990);
    `CHECK("window hold", 1'b0, role_active)
    ms(20);
    `CHECK("standby primary", 1'b1, role_active)
    `CHECK("relay at window", 1'b1, relay)
    $display("test window done");
    wrap_up();
  end
endmodule
